// File: design/board_regs.sv
// board control and status register bank behind an APB slave
`timescale 1ns/1ps
// Functional notes
// [R01] core speed bit 0: 0 means at most 1000 MHz, 1 above.
// [R02] core speed bytes drive no strap, still count in checksum; software writes 00.
// [R03] PLL timeout bit: 0 waits until timeout, 1 waits forever for lock.
// [R04] three lane selects: 0 same-numbered carrier lane, 1 lanes 4, 10, 11.
// [R05] configuration accepted only when 17 bytes sum to zero, else default strapping.
// [R06] checksum is taken modulo 256.
// [R07] erase bit sets all user flash bytes to FF, self-clears, reads zero.
// [R08] reload bit resets CPU and reads configuration from user flash, self-clears.
// [R09] busy bit 7 high during erase, read or write; accesses then not allowed.
// [R10] switch bits 0-3 read 1 when input low; fourth switch forces defaults.
// [R11] boot flash field bits 4-5: standard, recovery, external, reserved.
// [R12] writing 1 to bit 5 toggles standard and recovery boot flash.
// [R13] SPI and NOR protect: 0 drives high, 1 releases to high impedance.
// [R14] EEPROM protect: 0 drives low, 1 releases; powers up as 1.
// [R15] memory module protect: 0 releases, 1 drives high; powers up as 1.
// [R16] watchdog reset flag bit 0 set by watchdog reset, write 1 clears.
// [R17] cold reset flag bit 7 powers up 1, warm reset clears, write 1 clears.
// [R18] eight-bit register holds high byte of board identification.
module board_regs #(
  parameter logic [7:0] BOARD_ID_HIGH = 8'h5A,  // arbitrary value, set per board
  parameter int         PROG_CYCLES   = 1
) (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          resetn_i,
  // register bus
  input  wire board_regs_pkg::apb_req_t      apb_i,
  output      board_regs_pkg::apb_rsp_t      apb_o,
  // board inputs
  input  wire logic [3:0]                    switch_n_i,
  input  wire logic                          boot_flash_external_i,
  input  wire logic                          watchdog_reset_i,
  input  wire logic                          warm_reset_i,
  // cpu strapping and control
  output      logic                          cpu_reset_o,
  output      logic                          strap_default_o,
  output      logic                          pll_wait_forever_o,
  output      logic                          lane_one_route_o,
  output      logic                          lane_two_route_o,
  output      logic                          lane_three_route_o,
  output      logic                          user_flash_busy_o,
  output      logic                          boot_flash_recovery_o,
  // status and debug bytes
  output      logic [15:0]                   post_code_o,
  output      logic [15:0]                   debug_scratch_o,
  // write protect pins
  output      board_regs_pkg::protect_pins_t protect_o
);
  import board_regs_pkg::*;

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (PROG_CYCLES < 1 || PROG_CYCLES > 255) begin : g_bad_prog
    $error("PROG_CYCLES must be 1 to 255");
  end

  localparam logic [7:0] PROG_CNT = PROG_CYCLES[7:0];

  state_t q;
  state_t d;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  logic [IDX_W-1:0] idx;
  logic             setup;
  logic             wr;
  logic             hit;
  logic             idle;
  logic [7:0]       wbyte;
  logic [7:0]       sum;
  logic             sum_ok;
  logic [1:0]       bf_field;
  logic [7:0]       rd_val;
  logic             cfg_hit;
  logic [4:0]       cfg_slot;

  assign idx   = apb_i.paddr[ADDR_W-1:2];
  assign setup = apb_i.psel & ~apb_i.penable;
  // writes land only at the completing edge; pready is always high
  assign wr    = apb_i.psel & apb_i.penable & apb_i.pwrite & apb_i.pstrb[0] & ~q.err;
  assign wbyte = apb_i.pwdata[7:0];
  assign idle  = (q.fst == FL_IDLE);

  // checksum takes the last image slot; the lane byte stays outside the sum
  assign cfg_hit  = (idx < IDX_LANE_MUX) || (idx == IDX_CHECKSUM);  // [R05]
  assign cfg_slot = (idx == IDX_CHECKSUM) ? CFG_LAST : idx[4:0];

  // modulo-256 sum of all seventeen configuration bytes
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < CFG_BYTES; i++) begin
      sum = sum + q.cfg[i];  // [R06]
    end
  end

  assign sum_ok = (sum == SUM_OK);  // [R05]

  // external boot source overrides the standard/recovery pair
  assign bf_field = boot_flash_external_i ? BF_EXTERNAL :
                    (q.recovery ? BF_RECOVERY : BF_STANDARD);  // [R11]

  // ****************************************************************
  // read mux and address decode
  // ****************************************************************
  always_comb begin
    rd_val = 8'h00;
    hit    = 1'b1;
    if (apb_i.paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (cfg_hit) begin
      rd_val = q.cfg[cfg_slot];  // [R01] [R02]
    end else begin
      case (idx)
        IDX_LANE_MUX:   rd_val = q.lane_mux;  // [R04]
        IDX_ERASE:      rd_val = 8'h00;  // [R07]
        IDX_FLASH_CTRL: rd_val = {~idle, 7'h00};  // [R09]
        IDX_POST_LO:    rd_val = q.post[7:0];
        IDX_POST_HI:    rd_val = q.post[15:8];
        IDX_DBG_LO:     rd_val = q.dbg[7:0];
        IDX_DBG_HI:     rd_val = q.dbg[15:8];
        IDX_SW_STATUS:  rd_val = {2'b00, bf_field, ~switch_n_i};  // [R10] [R11]
        IDX_BOOT_CTRL:  rd_val = {2'b00, q.toggle, 5'h00};
        IDX_PROTECT:    rd_val = q.wp;
        IDX_RST_CAUSE:  rd_val = {q.cold, 6'h00, q.wd_flag};
        IDX_IRQ_ROUTE:  rd_val = 8'h00;  // present but not implemented
        IDX_ID_HIGH:    rd_val = q.id_high;  // [R18]
        default:        hit = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d = q;
    // read data and error captured in setup, shown during access
    if (setup) begin
      d.rdata = rd_val;
      d.err   = ~hit;
    end

    // user flash sequencer walks one byte per cycle
    case (q.fst)
      FL_IDLE: begin
        d.ptr = 5'd0;
      end
      FL_ERASE: begin
        d.flash[q.ptr] = FLASH_ERASED;  // [R07]
        d.ptr          = q.ptr + 5'd1;
        if (q.ptr == CFG_LAST) begin
          d.fst = FL_IDLE;
        end
      end
      FL_LOAD: begin
        d.cfg[q.ptr] = q.flash[q.ptr];  // [R08]
        d.ptr        = q.ptr + 5'd1;
        if (q.ptr == CFG_LAST) begin
          d.fst = FL_IDLE;
        end
      end
      FL_PROG: begin
        d.cnt = q.cnt - 8'd1;
        if (q.cnt == 8'd1) begin
          d.fst = FL_IDLE;
        end
      end
      default: begin
        d.fst = FL_IDLE;
      end
    endcase

    // register writes; flash-related ones are dropped while busy
    if (wr) begin
      if (cfg_hit) begin
        if (idle) begin  // [R09]
          d.cfg[cfg_slot]   = wbyte;  // [R02]
          d.flash[cfg_slot] = wbyte;
          d.fst             = FL_PROG;
          d.cnt             = PROG_CNT;
        end
      end else begin
        case (idx)
          IDX_ERASE: begin
            if (idle && wbyte[ACTION_BIT]) begin
              d.fst = FL_ERASE;  // [R07]
            end
          end
          IDX_FLASH_CTRL: begin
            if (idle && wbyte[ACTION_BIT]) begin
              d.fst = FL_LOAD;  // [R08]
            end
          end
          IDX_LANE_MUX:  d.lane_mux   = wbyte;  // [R04]
          IDX_POST_LO:   d.post[7:0]  = wbyte;
          IDX_POST_HI:   d.post[15:8] = wbyte;
          IDX_DBG_LO:    d.dbg[7:0]   = wbyte;
          IDX_DBG_HI:    d.dbg[15:8]  = wbyte;
          IDX_BOOT_CTRL: begin
            d.toggle = wbyte[TOGGLE_BIT];
            if (wbyte[TOGGLE_BIT]) begin
              d.recovery = ~q.recovery;  // [R12]
            end
          end
          IDX_PROTECT:   d.wp = wbyte & PROTECT_MASK;
          IDX_RST_CAUSE: begin
            if (wbyte[WD_FLAG_BIT]) begin
              d.wd_flag = 1'b0;  // [R16]
            end
            if (wbyte[COLD_FLAG_BIT]) begin
              d.cold = 1'b0;  // [R17]
            end
          end
          IDX_ID_HIGH:   d.id_high = wbyte;  // [R18]
          default: begin
          end
        endcase
      end
    end

    // hardware events come last so a set beats a same-cycle clear
    if (watchdog_reset_i) begin
      d.wd_flag = 1'b1;  // [R16]
    end
    if (warm_reset_i) begin
      d.cold = 1'b0;  // [R17]
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q          <= '0;
      q.fst      <= FL_IDLE;
      q.cfg      <= {CFG_BYTES{CFG_RST}};
      q.lane_mux <= CFG_RST;
      q.flash    <= {CFG_BYTES{FLASH_ERASED}};
      q.id_high  <= BOARD_ID_HIGH;
      q.wp       <= PROTECT_RST;  // [R14] [R15]
      q.cold     <= 1'b1;  // [R17]
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // zero wait states keep the master simple; error on unmapped words and on any address not word aligned
  assign apb_o.pready  = 1'b1;
  assign apb_o.prdata  = {24'h000000, q.rdata};
  assign apb_o.pslverr = apb_i.psel & apb_i.penable & q.err;

  // cpu held in reset for the whole reload walk
  assign cpu_reset_o       = (q.fst == FL_LOAD);  // [R08]
  assign user_flash_busy_o = ~idle;  // [R09]
  // bad checksum or the default switch both fall back to defaults
  assign strap_default_o   = ~sum_ok | ~switch_n_i[3];  // [R05] [R10]
  // default strapping for the pll wait is the reset value of its byte
  assign pll_wait_forever_o = strap_default_o ? CFG_RST[PLL_WAIT_BIT]
                                              : q.cfg[IDX_PLL_TO[4:0]][PLL_WAIT_BIT];  // [R03]
  assign lane_one_route_o   = q.lane_mux[LANE1_BIT];  // [R04]
  assign lane_two_route_o   = q.lane_mux[LANE2_BIT];  // [R04]
  assign lane_three_route_o = q.lane_mux[LANE3_BIT];  // [R04]
  assign boot_flash_recovery_o = q.recovery;
  assign post_code_o       = q.post;
  assign debug_scratch_o   = q.dbg;

  // protect pins: levels are fixed, only the enables follow the bits
  assign protect_o.spi_o   = 1'b1;
  assign protect_o.spi_oe  = ~q.wp[SPI_WP_BIT];  // [R13]
  assign protect_o.nor_o   = 1'b1;
  assign protect_o.nor_oe  = ~q.wp[NOR_WP_BIT];  // [R13]
  assign protect_o.ee_o    = 1'b0;
  assign protect_o.ee_oe   = ~q.wp[EE_WP_BIT];  // [R14]
  assign protect_o.dimm_o  = 1'b1;
  assign protect_o.dimm_oe = q.wp[DIMM_WP_BIT];  // [R15]

endmodule

// File: inc/board_regs_pkg.sv
// shared constants, types and register map of the board control register bank
package board_regs_pkg;

  // ****************************************************************
  // bus and register indices (byte address is four times the index)
  // ****************************************************************
  localparam int          ADDR_W         = 12;
  localparam int          IDX_W          = 10;
  localparam int          CFG_BYTES      = 17;            // 16 config bytes plus checksum
  localparam logic [4:0]  CFG_LAST       = 5'h10;
  localparam logic [9:0]  IDX_CORE0      = 10'h00D;
  localparam logic [9:0]  IDX_CORE1      = 10'h00E;
  localparam logic [9:0]  IDX_PLL_TO     = 10'h00F;
  localparam logic [9:0]  IDX_LANE_MUX   = 10'h010;
  localparam logic [9:0]  IDX_CHECKSUM   = 10'h011;
  localparam logic [9:0]  IDX_ERASE      = 10'h012;
  localparam logic [9:0]  IDX_FLASH_CTRL = 10'h013;
  localparam logic [9:0]  IDX_POST_LO    = 10'h080;
  localparam logic [9:0]  IDX_POST_HI    = 10'h081;
  localparam logic [9:0]  IDX_DBG_LO     = 10'h084;
  localparam logic [9:0]  IDX_DBG_HI     = 10'h085;
  localparam logic [9:0]  IDX_SW_STATUS  = 10'h280;
  localparam logic [9:0]  IDX_BOOT_CTRL  = 10'h282;
  localparam logic [9:0]  IDX_PROTECT    = 10'h284;
  localparam logic [9:0]  IDX_RST_CAUSE  = 10'h285;
  localparam logic [9:0]  IDX_IRQ_ROUTE  = 10'h286;
  localparam logic [9:0]  IDX_ID_HIGH    = 10'h288;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  CFG_RST        = 8'hFF;
  localparam logic [7:0]  FLASH_ERASED   = 8'hFF;
  localparam logic [7:0]  PROTECT_RST    = 8'h0A;
  localparam logic [7:0]  PROTECT_MASK   = 8'h1B;
  localparam logic [7:0]  SUM_OK         = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          CORE_FAST_BIT  = 0;
  localparam int          PLL_WAIT_BIT   = 0;
  localparam int          LANE1_BIT      = 0;
  localparam int          LANE2_BIT      = 1;
  localparam int          LANE3_BIT      = 2;
  localparam int          ACTION_BIT     = 0;
  localparam int          BUSY_BIT       = 7;
  localparam int          TOGGLE_BIT     = 5;
  localparam int          SPI_WP_BIT     = 0;
  localparam int          EE_WP_BIT      = 1;
  localparam int          DIMM_WP_BIT    = 3;
  localparam int          NOR_WP_BIT     = 4;
  localparam int          WD_FLAG_BIT    = 0;
  localparam int          COLD_FLAG_BIT  = 7;
  localparam logic [1:0]  BF_STANDARD    = 2'b00;
  localparam logic [1:0]  BF_RECOVERY    = 2'b01;
  localparam logic [1:0]  BF_EXTERNAL    = 2'b10;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ERASE = 2'b01,
    FL_LOAD  = 2'b11,
    FL_PROG  = 2'b10
  } flash_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic spi_o;
    logic spi_oe;
    logic ee_o;
    logic ee_oe;
    logic dimm_o;
    logic dimm_oe;
    logic nor_o;
    logic nor_oe;
  } protect_pins_t;

  typedef struct packed {
    flash_state_t                fst;
    logic [4:0]                  ptr;
    logic [7:0]                  cnt;
    logic [CFG_BYTES-1:0][7:0]   cfg;
    logic [CFG_BYTES-1:0][7:0]   flash;
    logic [7:0]                  lane_mux;
    logic [15:0]                 post;
    logic [15:0]                 dbg;
    logic [7:0]                  id_high;
    logic                        recovery;
    logic                        toggle;
    logic [7:0]                  wp;
    logic                        wd_flag;
    logic                        cold;
    logic [7:0]                  rdata;
    logic                        err;
  } state_t;

endpackage

// File: verif/board_host.sv
// host processor model that masters the register bus
`timescale 1ns/1ps
module board_host (
  // clock
  input  wire logic                     sys_clk_i,
  // register bus
  input  wire board_regs_pkg::apb_rsp_t rsp_i,
  output      board_regs_pkg::apb_req_t req_o
);
  import board_regs_pkg::*;
  // ****************************************************************
  // bus transfers
  // ****************************************************************
  logic stuck = 1'b0;
  initial req_o = '0;
  // setup, then access held until pready; released lines show inverted junk
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    int n;
    begin
      n = 0;
      req_o <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, wd}, 4'hF};
      @(posedge sys_clk_i);
      req_o.penable <= 1'b1;
      do begin
        @(posedge sys_clk_i);
        n++;
      end while (rsp_i.pready !== 1'b1 && n < 64);
      rd = rsp_i.prdata[7:0];
      err = rsp_i.pslverr;
      stuck = stuck | (rsp_i.pready !== 1'b1);
      req_o.psel <= 1'b0;
      req_o.penable <= 1'b0;
      req_o.paddr <= ~req_o.paddr;
      req_o.pwdata <= ~req_o.pwdata;
      @(posedge sys_clk_i);
    end
  endtask
  // polls the busy flag: no flash access may start while it is up
  task automatic wait_idle;
    logic [7:0] rd;
    logic       e;
    int         k;
    begin
      k = 0;
      do begin
        xfer(1'b0, IDX_FLASH_CTRL, 8'h00, rd, e);
        k++;
      end while (rd[BUSY_BIT] !== 1'b0 && k < 64);
      stuck = stuck | (rd[BUSY_BIT] !== 1'b0);
    end
  endtask
endmodule

// File: verif/board_regs_props.sv
// assertion checker for the board control register bank
`timescale 1ns/1ps
module board_regs_props (
  input wire logic                          sys_clk_i,
  input wire logic                          resetn_i,
  input wire board_regs_pkg::apb_req_t      apb_i,
  input wire board_regs_pkg::apb_rsp_t      apb_o,
  input wire logic [3:0]                    switch_n_i,
  input wire logic                          cpu_reset_o,
  input wire logic                          strap_default_o,
  input wire logic                          pll_wait_forever_o,
  input wire logic                          user_flash_busy_o,
  input wire logic                          boot_flash_recovery_o,
  input wire board_regs_pkg::protect_pins_t protect_o
);
  import board_regs_pkg::*;
  // ****************************************************************
  // helpers and checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  logic acc;
  logic wr1;
  // access phase, and a write that carries the low byte strobe
  assign acc = apb_i.psel && apb_i.penable;
  assign wr1 = acc && apb_i.pwrite && apb_i.pstrb[0];
  sequence busy17;
    user_flash_busy_o [*8] ##1 user_flash_busy_o [*8] ##1 user_flash_busy_o;
  endsequence
  sequence walk17;
    (cpu_reset_o && user_flash_busy_o) [*8] ##1 (cpu_reset_o && user_flash_busy_o) [*8] ##1 cpu_reset_o;
  endsequence
  chk_erase_busy_len: assert property (
    wr1 && apb_i.paddr == {IDX_ERASE, 2'b00} && apb_i.pwdata[ACTION_BIT] && !user_flash_busy_o
    |-> ##1 busy17 ##1 !user_flash_busy_o) else $error("erase busy length wrong");
  chk_reload_walk: assert property (
    wr1 && apb_i.paddr == {IDX_FLASH_CTRL, 2'b00} && apb_i.pwdata[ACTION_BIT] && !user_flash_busy_o
    |-> ##1 walk17 ##1 !cpu_reset_o) else $error("reload walk length wrong");
  chk_busy_readback: assert property (
    apb_i.psel && !apb_i.penable && !apb_i.pwrite && apb_i.paddr == {IDX_FLASH_CTRL, 2'b00}
    |=> apb_o.prdata[BUSY_BIT] == $past(user_flash_busy_o)) else $error("busy bit readback wrong");
  chk_erase_reads_zero: assert property (acc && apb_i.paddr == {IDX_ERASE, 2'b00} |-> apb_o.prdata == 32'h0)
    else $error("erase register read not zero");
  chk_toggle_flip: assert property (
    wr1 && apb_i.paddr == {IDX_BOOT_CTRL, 2'b00} && apb_i.pwdata[TOGGLE_BIT]
    |=> boot_flash_recovery_o != $past(boot_flash_recovery_o)) else $error("boot flash did not toggle");
  chk_toggle_hold: assert property (
    wr1 && apb_i.paddr == {IDX_BOOT_CTRL, 2'b00} && !apb_i.pwdata[TOGGLE_BIT]
    |=> $stable(boot_flash_recovery_o)) else $error("boot flash changed on zero");
  chk_switch_default: assert property (!switch_n_i[3] |-> strap_default_o)
    else $error("switch did not force defaults");
  chk_pll_default: assert property (strap_default_o |-> pll_wait_forever_o)
    else $error("pll wait not forced with defaults");
  chk_protect_level: assert property (
    protect_o.spi_o && !protect_o.ee_o && protect_o.dimm_o && protect_o.nor_o) else $error("protect level wrong");
  chk_err_in_access: assert property (apb_o.pslverr |-> acc) else $error("error outside access phase");
endmodule

bind board_regs board_regs_props u_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .apb_i(apb_i), .apb_o(apb_o),
  .switch_n_i(switch_n_i), .cpu_reset_o(cpu_reset_o), .strap_default_o(strap_default_o),
  .pll_wait_forever_o(pll_wait_forever_o), .user_flash_busy_o(user_flash_busy_o),
  .boot_flash_recovery_o(boot_flash_recovery_o), .protect_o(protect_o));

// File: verif/board_regs_tb.sv
// self-checking bench for the board control register bank
`timescale 1ns/1ps
module board_regs_tb;
  import board_regs_pkg::*;
  // ****************************************************************
  // bench
  // ****************************************************************
  localparam logic [7:0] ID_HI = 8'h3C;  // arbitrary board id byte
  logic          sys_clk_i = 1'b0;
  logic          resetn_i  = 1'b0;
  logic [3:0]    switch_n_i = 4'hF;
  logic          ext_i = 1'b0;
  logic          wd_i = 1'b0;
  logic          warm_i = 1'b0;
  apb_req_t      apb_req;
  apb_rsp_t      apb_rsp;
  logic          cpu_reset, strap_def, pll_wait, busy, recov;
  logic [2:0]    lanes;
  logic [15:0]   post, dbg;
  protect_pins_t prot;
  int            mismatches = 0;
  int            compares = 0;
  logic [7:0]    rd, v, sum;
  logic          err;
  logic [7:0]    cfg [18];
  logic [9:0]    ridx [16] = '{IDX_CORE0, IDX_CORE1, IDX_PLL_TO, IDX_LANE_MUX, IDX_CHECKSUM, IDX_ERASE,
    IDX_FLASH_CTRL, IDX_POST_LO, IDX_POST_HI, IDX_DBG_LO, IDX_DBG_HI, IDX_SW_STATUS, IDX_BOOT_CTRL,
    IDX_PROTECT, IDX_RST_CAUSE, IDX_ID_HIGH};
  logic [7:0]    rval [16] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h0A, 8'h80, ID_HI};
  // free-running 200 MHz clock
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  board_host host (.sys_clk_i(sys_clk_i), .rsp_i(apb_rsp), .req_o(apb_req));
  board_regs #(.BOARD_ID_HIGH(ID_HI), .PROG_CYCLES(1)) dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .apb_i(apb_req), .apb_o(apb_rsp), .switch_n_i(switch_n_i), .boot_flash_external_i(ext_i),
    .watchdog_reset_i(wd_i), .warm_reset_i(warm_i), .cpu_reset_o(cpu_reset), .strap_default_o(strap_def),
    .pll_wait_forever_o(pll_wait), .lane_one_route_o(lanes[0]), .lane_two_route_o(lanes[1]),
    .lane_three_route_o(lanes[2]), .user_flash_busy_o(busy), .boot_flash_recovery_o(recov),
    .post_code_o(post), .debug_scratch_o(dbg), .protect_o(prot));
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one bus cycle; flash-side writes wait for idle first, a hung bus ends the run
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    if (w && idx <= IDX_FLASH_CTRL) host.wait_idle();
    host.xfer(w, idx, d, rd, err);
    if (host.stuck) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e, input string what);
    bus(1'b0, idx, 8'h00);
    cmp(what, e, rd);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h4E4FFEA6));
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    foreach (ridx[i]) rdchk(ridx[i], rval[i], "reset value");
    cmp("strap default", 8'h01, 8'(strap_def));
    cmp("protect enables", 8'h0B, {4'h0, prot.spi_oe, prot.ee_oe, prot.dimm_oe, prot.nor_oe});
    bus(1'b1, 10'h3FF, 8'hA5);
    cmp("unmapped error", 8'h01, 8'(err));
    // valid checksum over random bytes; the lane byte at slot 16 is outside the sum
    sum = 8'h00;
    for (int i = 0; i < 17; i++) begin
      cfg[i] = (i == 0 || i == 13 || i == 14) ? 8'h00 : 8'($urandom);
      if (i != 16) sum += cfg[i];
    end
    cfg[17] = 8'h00 - sum;
    for (int i = 0; i < 18; i++) bus(1'b1, 10'(i), cfg[i]);
    host.wait_idle();
    cmp("strap default", 8'h00, 8'(strap_def));
    cmp("pll wait", 8'(cfg[15][PLL_WAIT_BIT]), 8'(pll_wait));
    cmp("lane routes", 8'(cfg[16][2:0]), 8'(lanes));
    rdchk(IDX_CORE0, cfg[13], "core speed");
    switch_n_i <= 4'($urandom);
    @(posedge sys_clk_i);
    rdchk(IDX_SW_STATUS, {4'h0, ~switch_n_i}, "switch status");
    cmp("strap default", {7'h00, ~switch_n_i[3]}, 8'(strap_def));
    switch_n_i <= 4'hF;
    bus(1'b1, IDX_CHECKSUM, cfg[17] + 8'h01);
    host.wait_idle();
    cmp("strap default", 8'h01, 8'(strap_def));
    // erase keeps live bytes; reload then brings back all ones
    bus(1'b1, IDX_ERASE, 8'h01);
    rdchk(IDX_FLASH_CTRL, 8'h80, "busy flag");
    rdchk(IDX_ERASE, 8'h00, "erase readback");
    host.wait_idle();
    rdchk(IDX_PLL_TO, cfg[15], "pll byte");
    bus(1'b1, IDX_FLASH_CTRL, 8'h01);
    cmp("cpu reset", 8'h01, 8'(cpu_reset));
    host.wait_idle();
    cmp("cpu reset", 8'h00, 8'(cpu_reset));
    rdchk(IDX_PLL_TO, FLASH_ERASED, "reloaded byte");
    rdchk(IDX_FLASH_CTRL, 8'h00, "reload bit clear");
    // boot flash toggle, a zero write between two ones
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, IDX_BOOT_CTRL, (i == 1) ? 8'h00 : 8'h20);
      rdchk(IDX_SW_STATUS, {2'b00, (i < 2) ? BF_RECOVERY : BF_STANDARD, 4'h0}, "boot field");
    end
    ext_i <= 1'b1;
    @(posedge sys_clk_i);
    rdchk(IDX_SW_STATUS, {2'b00, BF_EXTERNAL, 4'h0}, "boot field");
    ext_i <= 1'b0;
    // protect bits with random data
    repeat (6) begin
      v = 8'($urandom);
      bus(1'b1, IDX_PROTECT, v);
      cmp("protect enables", {4'h0, ~v[0], ~v[1], v[3], ~v[4]},
          {4'h0, prot.spi_oe, prot.ee_oe, prot.dimm_oe, prot.nor_oe});
    end
    // post and debug bytes reach their outputs
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      bus(1'b1, ridx[i + 7], v);
      cmp("post debug out", v, (i < 2) ? post[8*(i%2) +: 8] : dbg[8*(i%2) +: 8]);
    end
    // reset cause flags
    wd_i <= 1'b1;
    @(posedge sys_clk_i);
    wd_i <= 1'b0;
    rdchk(IDX_RST_CAUSE, 8'h81, "reset cause");
    bus(1'b1, IDX_RST_CAUSE, 8'h01);
    rdchk(IDX_RST_CAUSE, 8'h80, "reset cause");
    warm_i <= 1'b1;
    @(posedge sys_clk_i);
    warm_i <= 1'b0;
    rdchk(IDX_RST_CAUSE, 8'h00, "reset cause");
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rdchk(IDX_RST_CAUSE, 8'h80, "reset cause");
    bus(1'b1, IDX_RST_CAUSE, 8'h80);
    rdchk(IDX_RST_CAUSE, 8'h00, "reset cause");
    test_done();
  end
endmodule
